// *** shared/async_bus_pkg.sv ***
// Package for the asynchronous strobe bus controller: register map, fields, timing.
// Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz system clock.
package async_bus_pkg;

    localparam int NUM_SELECTS = 4;

    // Printed register indexes; not all are multiples of four, so byte address = 4 * index
    localparam logic [7:0] IDX_SELECT0_LOW_BOUND = 8'ha8;
    localparam logic [7:0] IDX_SELECT1_LOW_BOUND = 8'hab;
    localparam logic [7:0] IDX_SELECT2_LOW_BOUND = 8'hae;
    localparam logic [7:0] IDX_SELECT3_LOW_BOUND = 8'hb1;
    localparam logic [7:0] IDX_SELECT0_HIGH_BOUND = 8'ha9;
    localparam logic [7:0] IDX_SELECT0_CONTROL = 8'haa;
    localparam logic [7:0] IDX_SELECT0_MODE = 8'hf0;
    localparam logic [7:0] IDX_ACCESS_ADDR = 8'hc0;
    localparam logic [7:0] IDX_ACCESS_DATA = 8'hc1;
    localparam logic [7:0] IDX_ACCESS_CMD = 8'hc2;
    localparam logic [7:0] IDX_ACCESS_STATUS = 8'hc3;
    localparam logic [7:0] SELECT_STRIDE = 8'h03;

    localparam logic [7:0] LOW_BOUND_RESET = 8'h00;
    localparam logic [7:0] HIGH_BOUND0_RESET = 8'hff;
    localparam logic [7:0] HIGH_BOUND_RESET = 8'h00;
    localparam logic [7:0] CONTROL0_RESET = 8'he8;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h02;

    // Control register fields
    localparam int CTL_PORT_SPACE_BIT = 4;
    localparam int CTL_ENABLE_BIT = 3;
    localparam logic [7:0] CONTROL_WR_MASK = 8'hf8;
    // Mode register fields
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam logic [7:0] MODE_WR_MASK = 8'hef;
    localparam logic [1:0] MODE_NATIVE = 2'h0;
    localparam logic [1:0] MODE_STROBE = 2'h3;

    // Command register fields
    localparam int CMD_READ_BIT = 0;
    localparam int CMD_PORT_BIT = 1;

    // Address byte lanes compared against the bounds
    localparam int MEM_BYTE_LSB = 16;
    localparam int PORT_BYTE_LSB = 8;

    localparam int STATE_CYCLES = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : async_bus_pkg

// *** hw/select_match.sv ***
// Address match for one chip select against its bound registers.
// Assumes bound and control bytes are stable register outputs.
`timescale 1ns/1ps
module select_match (
    // Configuration
    input  wire logic [7:0]  low_bound,
    input  wire logic [7:0]  high_bound,
    input  wire logic [7:0]  control,
    // Access
    input  wire logic [23:0] addr,
    input  wire logic        port_access,
    // Result
    output logic             hit
);
    logic port_space;
    logic enabled;
    logic [7:0] mem_byte;
    logic [7:0] port_byte;

    always_comb begin
        port_space = control[async_bus_pkg::CTL_PORT_SPACE_BIT];
        enabled    = control[async_bus_pkg::CTL_ENABLE_BIT];
        mem_byte   = addr[async_bus_pkg::MEM_BYTE_LSB +: 8];
        port_byte  = addr[async_bus_pkg::PORT_BYTE_LSB +: 8];
        if (!enabled || (port_space != port_access)) begin
            hit = 1'b0;
        end else if (port_space) begin
            // High bound is ignored for port space
            hit = (port_byte == low_bound);
        end else begin
            hit = (mem_byte >= low_bound) && (mem_byte <= high_bound);
        end
    end
endmodule : select_match

// *** hw/async_bus_ctrl.sv ***
// Strobe-and-acknowledge external bus controller with chip select decode.
// Assumes an AXI4-Lite master and a peripheral synchronous to aclk.
// Function
// - Read: latch data, release strobes entering S7
// - Write S0 restores read_not_write high
// - Address valid on entering write S1
// - S2 edge asserts address strobe, write low
// - S3 drives write data onto bus
// - S4 edge asserts data strobe, await acknowledge
// - Late acknowledge inserts whole-state stall cycles
// - Write S5, S6 hold outputs
// - S7 releases strobes; high after S7
// - Mode change inserts one-cycle delay
// - No delay for same or native mode
// - Memory select compares address bits 23:16
// - Port select compares address bits 15:8
// - Low bounds reset to zero
// - Low bounds fully read/write bytes
// - High bound limits memory range only
// - Control bit 4 picks port space
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module async_bus_ctrl #(
    parameter int STATE_CYCLES = async_bus_pkg::STATE_CYCLES
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // External bus
    output logic [23:0]      ext_addr,
    input  wire logic [7:0]  ext_data_in,
    output logic [7:0]       ext_data_out,
    output logic             ext_data_oe,
    output logic             address_strobe_n,
    output logic             data_strobe_n,
    output logic             read_not_write,
    input  wire logic        transfer_ack_n,
    output logic [3:0]       chip_select_n
);
    localparam int N = async_bus_pkg::NUM_SELECTS;
    localparam logic [3:0] LAST_TICK = 4'(STATE_CYCLES - 1);
    localparam int MODE_MSB_I = async_bus_pkg::MODE_MSB;
    localparam int MODE_LSB_I = async_bus_pkg::MODE_LSB;

    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_GAP  = 10'h002,
        ST_S0   = 10'h004,
        ST_S1   = 10'h008,
        ST_S2   = 10'h010,
        ST_S3   = 10'h020,
        ST_S4   = 10'h040,
        ST_S5   = 10'h080,
        ST_S6   = 10'h100,
        ST_S7   = 10'h200
    } bus_state_t;

    typedef struct packed {
        logic [N-1:0][7:0] low_bound;
        logic [N-1:0][7:0] high_bound;
        logic [N-1:0][7:0] control;
        logic [N-1:0][7:0] mode;
        logic [23:0]       acc_addr;
        logic [7:0]        acc_wdata;
        logic [7:0]        acc_rdata;
        logic              acc_read;
        logic              acc_port;
        logic              busy;
        logic              start;
        logic [1:0]        last_mode;
        bus_state_t        state;
        logic [3:0]        tick;
        logic              ack_seen;
        logic [1:0]        sel;
        logic              sel_valid;
        logic              as_n;
        logic              ds_n;
        logic              rnw;
        logic              doe;
        logic              aw_ready;
        logic              w_ready;
        logic              b_valid;
        logic [1:0]        b_resp;
        logic              ar_ready;
        logic              r_valid;
        logic [31:0]       r_data;
        logic [1:0]        r_resp;
    } ctrl_state_t;

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;
    logic [N-1:0] hit;

    // Register index from a byte address; sub-word bits ignored
    function automatic logic [7:0] reg_index(input logic [31:0] a);
        return a[9:2];
    endfunction : reg_index

    // Which select and which kind of register an index names
    function automatic logic [2:0] decode_select(input logic [7:0] idx, output logic [1:0] sel);
        logic [7:0] off;
        off = '0;
        sel = '0;
        decode_select = 3'h0;
        if (idx >= async_bus_pkg::IDX_SELECT0_MODE && idx < async_bus_pkg::IDX_SELECT0_MODE + 8'(N)) begin
            sel = 2'(idx - async_bus_pkg::IDX_SELECT0_MODE);
            decode_select = 3'h4;
        end else if (idx >= async_bus_pkg::IDX_SELECT0_LOW_BOUND
                     && idx < async_bus_pkg::IDX_SELECT0_LOW_BOUND + 8'(3 * N)) begin
            off = idx - async_bus_pkg::IDX_SELECT0_LOW_BOUND;
            sel = 2'(off / async_bus_pkg::SELECT_STRIDE);
            decode_select = 3'(off % async_bus_pkg::SELECT_STRIDE) + 3'h1;
        end
    endfunction : decode_select

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_match
            select_match u_match (
                .low_bound   (s_r.low_bound[g]),
                .high_bound  (s_r.high_bound[g]),
                .control     (s_r.control[g]),
                .addr        (s_r.acc_addr),
                .port_access (s_r.acc_port),
                .hit         (hit[g])
            );
        end
    endgenerate

    always_comb begin
        logic [7:0] widx;
        logic [7:0] ridx;
        logic [2:0] wkind;
        logic [2:0] rkind;
        logic [1:0] wsel;
        logic [1:0] rsel;
        logic [7:0] wbyte;
        logic [1:0] new_mode;
        logic       state_end;
        s_nxt = s_r;
        widx = reg_index(s_axi_awaddr);
        ridx = reg_index(s_axi_araddr);
        wkind = decode_select(widx, wsel);
        rkind = decode_select(ridx, rsel);
        wbyte = s_axi_wdata[7:0];
        new_mode = async_bus_pkg::MODE_NATIVE;
        state_end = (s_r.tick == LAST_TICK);
        s_nxt.start = 1'b0;

        // Write channel: take address and data together
        s_nxt.aw_ready = 1'b0;
        s_nxt.w_ready = 1'b0;
        if (s_axi_awvalid && s_axi_wvalid && !s_r.b_valid && !s_r.aw_ready) begin
            s_nxt.aw_ready = 1'b1;
            s_nxt.w_ready = 1'b1;
            s_nxt.b_resp = async_bus_pkg::RESP_OKAY;
            if (s_axi_wstrb[0]) begin
                case (wkind)
                    3'h1: s_nxt.low_bound[wsel] = wbyte;
                    3'h2: s_nxt.high_bound[wsel] = wbyte;
                    3'h3: s_nxt.control[wsel] = wbyte & async_bus_pkg::CONTROL_WR_MASK;
                    3'h4: s_nxt.mode[wsel] = wbyte & async_bus_pkg::MODE_WR_MASK;
                    default: begin
                        case (widx)
                            async_bus_pkg::IDX_ACCESS_ADDR: s_nxt.acc_addr = s_axi_wdata[23:0];
                            async_bus_pkg::IDX_ACCESS_DATA: s_nxt.acc_wdata = wbyte;
                            async_bus_pkg::IDX_ACCESS_CMD: begin
                                if (!s_r.busy) begin
                                    s_nxt.acc_read = s_axi_wdata[async_bus_pkg::CMD_READ_BIT];
                                    s_nxt.acc_port = s_axi_wdata[async_bus_pkg::CMD_PORT_BIT];
                                    s_nxt.busy = 1'b1;
                                    s_nxt.start = 1'b1;
                                end else begin
                                    s_nxt.b_resp = async_bus_pkg::RESP_SLVERR;
                                end
                            end
                            async_bus_pkg::IDX_ACCESS_STATUS: ;
                            default: s_nxt.b_resp = async_bus_pkg::RESP_SLVERR;
                        endcase
                    end
                endcase
            end
        end
        if (s_r.aw_ready) s_nxt.b_valid = 1'b1;
        if (s_r.b_valid && s_axi_bready) begin
            s_nxt.b_valid = 1'b0;
        end

        // Read channel
        s_nxt.ar_ready = 1'b0;
        if (s_axi_arvalid && !s_r.r_valid && !s_r.ar_ready) begin
            s_nxt.ar_ready = 1'b1;
            s_nxt.r_resp = async_bus_pkg::RESP_OKAY;
            s_nxt.r_data = '0;
            case (rkind)
                3'h1: s_nxt.r_data[7:0] = s_r.low_bound[rsel];
                3'h2: s_nxt.r_data[7:0] = s_r.high_bound[rsel];
                3'h3: s_nxt.r_data[7:0] = s_r.control[rsel];
                3'h4: s_nxt.r_data[7:0] = s_r.mode[rsel];
                default: begin
                    case (ridx)
                        async_bus_pkg::IDX_ACCESS_ADDR: s_nxt.r_data[23:0] = s_r.acc_addr;
                        async_bus_pkg::IDX_ACCESS_DATA: s_nxt.r_data[7:0] = s_r.acc_rdata;
                        async_bus_pkg::IDX_ACCESS_CMD: s_nxt.r_data[1:0] = {s_r.acc_port, s_r.acc_read};
                        async_bus_pkg::IDX_ACCESS_STATUS: s_nxt.r_data[0] = s_r.busy;
                        default: s_nxt.r_resp = async_bus_pkg::RESP_SLVERR;
                    endcase
                end
            endcase
        end
        if (s_r.ar_ready) s_nxt.r_valid = 1'b1;
        if (s_r.r_valid && s_axi_rready) begin
            s_nxt.r_valid = 1'b0;
        end

        // External bus sequencer
        s_nxt.tick = state_end ? 4'h0 : s_r.tick + 4'h1;
        case (s_r.state)
            ST_IDLE: begin
                s_nxt.tick = 4'h0;
                if (s_r.start) begin
                    s_nxt.sel_valid = |hit;
                    s_nxt.sel = 2'h0;
                    for (int i = N - 1; i >= 0; i--) begin
                        if (hit[i]) s_nxt.sel = 2'(i);
                    end
                    new_mode = (|hit) ? s_nxt.mode[s_nxt.sel][MODE_MSB_I:MODE_LSB_I] : async_bus_pkg::MODE_NATIVE;
                    s_nxt.last_mode = new_mode;
                    if (new_mode != s_r.last_mode && new_mode != async_bus_pkg::MODE_NATIVE) begin
                        s_nxt.state = ST_GAP;
                    end else begin
                        s_nxt.state = ST_S0;
                    end
                end
            end
            ST_GAP: begin
                s_nxt.tick = 4'h0;
                s_nxt.state = ST_S0;
            end
            ST_S0: begin
                s_nxt.rnw = 1'b1;
                if (state_end) s_nxt.state = ST_S1;
            end
            ST_S1: begin
                if (state_end) begin
                    s_nxt.state = ST_S2;
                    s_nxt.as_n = 1'b0;
                    s_nxt.rnw = s_r.acc_read;
                    if (s_r.acc_read) s_nxt.ds_n = 1'b0;
                end
            end
            ST_S2: if (state_end) s_nxt.state = ST_S3;
            ST_S3: begin
                if (!s_r.acc_read) s_nxt.doe = 1'b1;
                if (state_end) begin
                    s_nxt.state = ST_S4;
                    s_nxt.ds_n = 1'b0;
                    s_nxt.ack_seen = 1'b0;
                end
            end
            ST_S4: begin
                // Acknowledge must be seen a full cycle before the state ends
                if (!transfer_ack_n && !state_end) s_nxt.ack_seen = 1'b1;
                if (state_end) begin
                    if (s_r.ack_seen) s_nxt.state = ST_S5;
                    else s_nxt.ack_seen = !transfer_ack_n;
                end
            end
            ST_S5: if (state_end) s_nxt.state = ST_S6;
            ST_S6: begin
                if (state_end) begin
                    s_nxt.state = ST_S7;
                    s_nxt.as_n = 1'b1;
                    s_nxt.ds_n = 1'b1;
                    if (s_r.acc_read) s_nxt.acc_rdata = ext_data_in;
                end
            end
            ST_S7: begin
                if (state_end) begin
                    s_nxt.state = ST_IDLE;
                    s_nxt.rnw = 1'b1;
                    s_nxt.doe = 1'b0;
                    s_nxt.busy = 1'b0;
                    s_nxt.sel_valid = 1'b0;
                end
            end
            default: s_nxt.state = ST_IDLE;
        endcase

        if (!aresetn) begin
            s_nxt = '0;
            s_nxt.state = ST_IDLE;
            s_nxt.as_n = 1'b1;
            s_nxt.ds_n = 1'b1;
            s_nxt.rnw = 1'b1;
            for (int i = 0; i < N; i++) begin
                s_nxt.low_bound[i] = async_bus_pkg::LOW_BOUND_RESET;
                s_nxt.high_bound[i] = async_bus_pkg::HIGH_BOUND_RESET;
                s_nxt.control[i] = async_bus_pkg::CONTROL_RESET;
                s_nxt.mode[i] = async_bus_pkg::MODE_RESET;
            end
            s_nxt.high_bound[0] = async_bus_pkg::HIGH_BOUND0_RESET;
            s_nxt.control[0] = async_bus_pkg::CONTROL0_RESET;
        end
    end

    always_ff @(posedge aclk) begin
        s_r <= s_nxt;
    end

    always_comb begin
        s_axi_awready = s_r.aw_ready;
        s_axi_wready = s_r.w_ready;
        s_axi_bvalid = s_r.b_valid;
        s_axi_bresp = s_r.b_resp;
        s_axi_arready = s_r.ar_ready;
        s_axi_rvalid = s_r.r_valid;
        s_axi_rdata = s_r.r_data;
        s_axi_rresp = s_r.r_resp;
        ext_addr = s_r.acc_addr;
        ext_data_out = s_r.acc_wdata;
        ext_data_oe = s_r.doe;
        address_strobe_n = s_r.as_n;
        data_strobe_n = s_r.ds_n;
        read_not_write = s_r.rnw;
        chip_select_n = '1;
        if (s_r.sel_valid && s_r.state != ST_IDLE && s_r.state != ST_GAP) begin
            chip_select_n[s_r.sel] = 1'b0;
        end
    end
endmodule : async_bus_ctrl

// *** verif/async_bus_ctrl_properties.sv ***
// Bus cycle checker for async_bus_ctrl, watching only its external bus ports.
// Assumes the far side holds acknowledge low until the strobes rise.
`timescale 1ns/1ps
module async_bus_ctrl_properties #(
    parameter int STATE_CYCLES = 2
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // External bus
    input wire logic [23:0] ext_addr,
    input wire logic [7:0]  ext_data_out,
    input wire logic        ext_data_oe,
    input wire logic        address_strobe_n,
    input wire logic        data_strobe_n,
    input wire logic        read_not_write,
    input wire logic        transfer_ack_n
);
    localparam int S7_HOLD = STATE_CYCLES - 1;
    localparam int S4_AT   = 2 * STATE_CYCLES;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_read_release: assert property (
        $rose(address_strobe_n) && read_not_write |-> $rose(data_strobe_n))
        else $error("read strobes not released together");
    a_write_release: assert property (
        $rose(address_strobe_n) && !read_not_write |-> $rose(data_strobe_n) ##S7_HOLD !read_not_write ##1 read_not_write)
        else $error("write end sequence wrong");
    a_write_strobe: assert property (
        $fell(address_strobe_n) && !read_not_write |-> $fell(read_not_write) && data_strobe_n)
        else $error("write address strobe without direction low");
    a_write_drive: assert property (
        $fell(address_strobe_n) && !read_not_write |-> ##[2:3] ext_data_oe)
        else $error("write data not driven in third state");
    a_ds_at_s4: assert property (
        $fell(address_strobe_n) && !read_not_write |-> ##S4_AT $fell(data_strobe_n))
        else $error("write data strobe not at fourth state");
    a_hold_s5s6: assert property (
        !address_strobe_n && !data_strobe_n && !$past(data_strobe_n)
        |-> $stable(ext_addr) && $stable(ext_data_out) && $stable(ext_data_oe) && $stable(read_not_write))
        else $error("bus outputs moved while strobed");
    a_ack_seen: assert property (
        $rose(data_strobe_n) |-> !$past(transfer_ack_n))
        else $error("cycle ended without acknowledge");
    a_stall_wait: assert property (
        $rose(data_strobe_n) |-> !$past(transfer_ack_n, S4_AT + 2))
        else $error("data strobe ended without early acknowledge");
    a_addr_setup: assert property (
        $fell(address_strobe_n) |-> $stable(ext_addr))
        else $error("address moved at address strobe");
endmodule : async_bus_ctrl_properties

bind async_bus_ctrl async_bus_ctrl_properties #(.STATE_CYCLES(STATE_CYCLES)) chk_u (
    .aclk(aclk), .aresetn(aresetn), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
    .read_not_write(read_not_write), .transfer_ack_n(transfer_ack_n));

// *** verif/strobe_peripheral.sv ***
// Far-side peripheral model: acknowledge after a set delay, read data on demand.
// Assumes strobes and direction come from async_bus_ctrl on aclk.
`timescale 1ns/1ps
module strobe_peripheral (
    // Clock
    input  wire logic       aclk,
    // Bus from controller
    input  wire logic       data_strobe_n,
    input  wire logic       read_not_write,
    // Scenario control
    input  wire logic [3:0] ack_delay,
    input  wire logic [7:0] rd_byte,
    // Answer
    output logic [7:0]      ext_data_in,
    output logic            transfer_ack_n
);
    logic [3:0] wait_cnt = 4'h0;

    always @(posedge aclk) begin
        if (data_strobe_n) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt != 4'hf) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    // Combinational so a zero delay answers within the first S4 cycle
    assign transfer_ack_n = data_strobe_n | (wait_cnt < ack_delay);
    // Inverse when not read-selected, so stale data never looks valid
    assign ext_data_in = (!data_strobe_n && read_not_write) ? rd_byte : ~rd_byte;
endmodule : strobe_peripheral

// *** verif/tb_async_bus_ctrl.sv ***
// Self-checking bench for async_bus_ctrl with strobe_peripheral on the far side.
// Assumes the register map and state length of async_bus_pkg.
`timescale 1ns/1ps
module tb_async_bus_ctrl;
    localparam int SC = 2;
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb = 4'hf, ack_delay = 4'h0, chip_select_n, seen_cs;
    logic [23:0] ext_addr;
    logic [7:0]  ext_data_in, ext_data_out, seen_wd, rd_byte = 8'h0;
    logic        ext_data_oe, address_strobe_n, data_strobe_n, read_not_write, transfer_ack_n;
    logic [31:0] pat [3] = '{32'hff, 32'h5a, 32'h0};
    int          gap, low, fail_count = 0, tests_run = 0;

    always #10 aclk = ~aclk;

    async_bus_ctrl #(.STATE_CYCLES(SC)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ext_addr(ext_addr), .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
        .ext_data_oe(ext_data_oe), .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
        .read_not_write(read_not_write), .transfer_ack_n(transfer_ack_n), .chip_select_n(chip_select_n));

    strobe_peripheral peer_u (
        .aclk(aclk), .data_strobe_n(data_strobe_n), .read_not_write(read_not_write),
        .ack_delay(ack_delay), .rd_byte(rd_byte), .ext_data_in(ext_data_in), .transfer_ack_n(transfer_ack_n));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic axi_write(input logic [7:0] idx, input logic [31:0] v,
                             input logic [1:0] er = async_bus_pkg::RESP_OKAY);
        s_axi_awaddr  <= {22'h0, idx, 2'h0};
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do @(posedge aclk); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid  <= 1'h0;
        while (s_axi_bvalid !== 1'h1) @(posedge aclk);
        check({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] idx, output logic [31:0] d,
                            input logic [1:0] er = async_bus_pkg::RESP_OKAY);
        s_axi_araddr  <= {22'h0, idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge aclk);
        d = s_axi_rdata & 32'hff;
        check({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask : axi_read

    // Counts cycles to address strobe and its low span, then waits for idle
    task automatic access(input logic [23:0] a, input logic [7:0] cmd);
        logic [31:0] st;
        axi_write(async_bus_pkg::IDX_ACCESS_ADDR, {8'h0, a});
        axi_write(async_bus_pkg::IDX_ACCESS_CMD, {24'h0, cmd});
        check({31'h0, read_not_write}, 32'h1);
        gap = 0;
        low = 0;
        while (address_strobe_n !== 1'h0) begin
            @(posedge aclk);
            gap++;
        end
        seen_cs = chip_select_n;
        check({8'h0, ext_addr}, {8'h0, a});
        while (address_strobe_n === 1'h0) begin
            if (data_strobe_n === 1'h0 && ext_data_oe === 1'h1) seen_wd = ext_data_out;
            @(posedge aclk);
            low++;
        end
        do axi_read(async_bus_pkg::IDX_ACCESS_STATUS, st); while (st[0] !== 1'h0);
    endtask : access

    task automatic t_regs();
        logic [7:0]  idx;
        logic [31:0] d;
        idx = async_bus_pkg::IDX_SELECT0_LOW_BOUND;
        for (int i = 0; i < 4; i++) begin
            axi_read(idx, d);
            check(d, 32'h0);
            foreach (pat[j]) begin
                axi_write(idx, pat[j]);
                axi_read(idx, d);
                check(d, pat[j]);
            end
            idx = idx + async_bus_pkg::SELECT_STRIDE;
        end
        axi_read(8'h10, d, async_bus_pkg::RESP_SLVERR);
        axi_write(8'h10, 32'h1, async_bus_pkg::RESP_SLVERR);
    endtask : t_regs

    task automatic t_cycle(input logic [7:0] cmd, input logic [3:0] dly, input int exp_low);
        logic [31:0] d;
        ack_delay <= dly;
        rd_byte   <= 8'h96 ^ {4'h0, dly};
        axi_write(async_bus_pkg::IDX_ACCESS_DATA, {24'h0, 8'h3c ^ {4'h0, dly}});
        access(24'h123456, cmd);
        check(32'(low), 32'(exp_low));
        check({28'h0, seen_cs}, 32'he);
        if (cmd[0]) begin
            axi_read(async_bus_pkg::IDX_ACCESS_DATA, d);
            check(d, {24'h0, rd_byte});
        end else begin
            check({24'h0, seen_wd}, {24'h0, 8'h3c ^ {4'h0, dly}});
        end
    endtask : t_cycle

    task automatic t_mode();
        int g0;
        access(24'h001000, 8'h00);
        g0 = gap;
        axi_write(async_bus_pkg::IDX_SELECT0_MODE, 32'hc0);
        access(24'h001000, 8'h00);
        check(32'(gap), 32'(g0 + 1));
        access(24'h001000, 8'h00);
        check(32'(gap), 32'(g0));
        axi_write(async_bus_pkg::IDX_SELECT0_MODE, 32'h0);
        access(24'h001000, 8'h00);
        check(32'(gap), 32'(g0));
    endtask : t_mode

    task automatic t_decode();
        logic [23:0] ta [7] = '{24'h200000, 24'h2fffff, 24'h300000, 24'h1f0000, 24'h550000, 24'h005500, 24'h005600};
        logic [3:0]  te [7] = '{4'hd, 4'hd, 4'hf, 4'hf, 4'hf, 4'hb, 4'hf};
        axi_write(async_bus_pkg::IDX_SELECT0_CONTROL, 32'h0);
        axi_write(async_bus_pkg::IDX_SELECT1_LOW_BOUND, 32'h20);
        axi_write(async_bus_pkg::IDX_SELECT0_HIGH_BOUND + async_bus_pkg::SELECT_STRIDE, 32'h2f);
        axi_write(async_bus_pkg::IDX_SELECT0_CONTROL + async_bus_pkg::SELECT_STRIDE, 32'h08);
        axi_write(async_bus_pkg::IDX_SELECT2_LOW_BOUND, 32'h55);
        axi_write(async_bus_pkg::IDX_SELECT2_LOW_BOUND + 8'h02, 32'h18);
        for (int i = 0; i < 7; i++) begin
            access(ta[i], (i > 4) ? 8'h02 : 8'h00);
            check({28'h0, seen_cs}, {28'h0, te[i]});
        end
    endtask : t_decode

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_regs();
        t_cycle(8'h00, 4'h0, 5 * SC);
        t_cycle(8'h00, 4'h6, 8 * SC);
        t_cycle(8'h01, 4'h0, 5 * SC);
        t_cycle(8'h01, 4'h6, 6 * SC);
        t_mode();
        t_decode();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        wrap_up();
    end
endmodule : tb_async_bus_ctrl
